//--- shared/psc_defines.vh
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// clock divider register fields
`define PSC_DIV_ROI_BIT 15
`define PSC_DIV_RATIO_HI 14
`define PSC_DIV_RATIO_LO 12
`define PSC_DIV_DOZE_ENABLE_BIT_BIT 11
`define PSC_DIV_RESET 16'h3000
// oscillator control register fields
`define PSC_OSC_NEW_HI 10
`define PSC_OSC_NEW_LO 8
`define PSC_OSC_RESET 16'h0000
// oscillator source codes
`define PSC_SRC_FRC 3'h0
`define PSC_SRC_FRC_PLL 3'h1
// power save operand codes
`define PSC_OP_SLEEP 1'b0
`define PSC_OP_IDLE 1'b1
// wake latency in clock cycles
`define PSC_WAKE_MIN 2
`define PSC_WAKE_MAX 4
`define PSC_WAKE_CYC 3'h3
// fail window in low-power rc ticks
`define PSC_FAIL_TICKS 4'h4
`endif

//--- logic/psc_doze_div.v
`include "psc_defines.vh"
// processor clock enable divider for doze operation
module psc_doze_div (
    input wire clk,
    input wire reset_n,
    input wire doze_on,
    input wire [2:0] ratio,
    input wire run,
    output reg cpu_tick_q
);
    reg [6:0] cnt_q; // divide counter
    wire [6:0] limit; // terminal count
    // powers of two, forced 1:1 when doze is off
    assign limit = doze_on ? ((7'h01 << ratio) - 7'h01) : 7'h00;
    // counter runs from peripheral clock, keeps domains aligned
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 7'h00;
            cpu_tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 7'h00;
            cpu_tick_q <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 7'h00;
            cpu_tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            cpu_tick_q <= 1'b0;
        end
    end
endmodule // psc_doze_div

//--- logic/psc_fail_mon.v
`include "psc_defines.vh"
// watches system clock activity against low-power rc ticks
module psc_fail_mon (
    input wire clk,
    input wire reset_n,
    input wire active,
    input wire low_power_rc_osc_tick,
    input wire sys_clk_seen,
    output reg fail_q
);
    reg [3:0] win_q; // ticks with no system clock edge
    // window restarts on each seen edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            win_q <= 4'h0;
            fail_q <= 1'b0;
        end else if (!active || sys_clk_seen) begin
            win_q <= 4'h0;
            fail_q <= 1'b0;
        end else if (low_power_rc_osc_tick) begin
            if (win_q >= `PSC_FAIL_TICKS - 4'h1) begin
                fail_q <= 1'b1;
            end else begin
                win_q <= win_q + 4'h1;
            end
        end
    end
endmodule // psc_fail_mon

//--- logic/psc_power_ctrl.v
`include "psc_defines.vh"
module psc_power_ctrl (
    input wire clk,
    input wire reset_n,
    input wire power_save_instr_exec,
    input wire power_save_instr_op,
    input wire irq_pending,
    input wire wdt_enable,
    input wire wdt_timeout,
    input wire fail_mon_enable,
    input wire low_power_rc_osc_tick,
    input wire sys_clk_seen,
    input wire pll_in_use,
    input wire cfg_locked,
    input wire div_wr,
    input wire [15:0] div_wdata,
    input wire osc_wr,
    input wire [15:0] osc_wdata,
    output reg [15:0] clock_divider_reg_q,
    output reg [15:0] osc_control_reg_q,
    output reg [2:0] cur_osc_q,
    output reg clock_fail_trap_q,
    output wire sys_clk_run,
    output wire low_power_rc_osc_run,
    output wire periph_clk_en,
    output wire cpu_clk_en,
    output wire cpu_running,
    output reg watchdog_clear_q,
    output wire in_sleep,
    output wire in_idle
);
    // one-hot power states
    localparam ST_RUN = 4'b0001;
    localparam ST_SLEEP = 4'b0010;
    localparam ST_IDLE = 4'b0100;
    localparam ST_WAKE = 4'b1000;

    reg [3:0] state_q; // power state
    reg [3:0] state_d; // next power state
    reg [2:0] wake_cnt_q; // idle resume latency
    reg [2:0] sleep_src_q; // source at sleep entry
    reg irq_hold_q; // coincident interrupt held
    wire fail_q; // monitor output
    wire cpu_tick; // divided processor enable
    wire wake_ev; // any wake cause
    wire doze_bit; // doze enable as stored

    // decode a one-hot state test, used several times
    function is_state;
        input [3:0] s;
        input [3:0] want;
        begin
            is_state = (s & want) != 4'h0;
        end
    endfunction

    assign in_sleep = is_state(state_q, ST_SLEEP);
    assign in_idle = is_state(state_q, ST_IDLE);
    assign doze_bit = clock_divider_reg_q[`PSC_DIV_DOZE_ENABLE_BIT_BIT];
    // wake causes; reset acts through reset_n itself
    assign wake_ev = irq_pending | irq_hold_q | wdt_timeout;

    // next power state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (power_save_instr_exec) begin
                    state_d = (power_save_instr_op == `PSC_OP_IDLE) ? ST_IDLE : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_ev) begin
                    state_d = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (wake_ev) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_q == 3'h1) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // state register, latency count, held interrupt
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RUN;
            wake_cnt_q <= 3'h0;
            irq_hold_q <= 1'b0;
            watchdog_clear_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // pulse watchdog clear on entry
            watchdog_clear_q <= is_state(state_q, ST_RUN) & power_save_instr_exec
                & wdt_enable;
            // interrupt during instruction held until entry done
            if (is_state(state_q, ST_RUN) && power_save_instr_exec && irq_pending) begin
                irq_hold_q <= 1'b1;
            end else if (!is_state(state_q, ST_RUN)) begin
                irq_hold_q <= 1'b0;
            end
            if (is_state(state_q, ST_IDLE) && wake_ev) begin
                wake_cnt_q <= `PSC_WAKE_CYC;
            end else if (wake_cnt_q != 3'h0) begin
                wake_cnt_q <= wake_cnt_q - 3'h1;
            end
        end
    end

    // register writes, fail switch-over, return on interrupt
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_divider_reg_q <= `PSC_DIV_RESET;
            osc_control_reg_q <= `PSC_OSC_RESET;
            cur_osc_q <= `PSC_SRC_FRC;
            sleep_src_q <= `PSC_SRC_FRC;
            clock_fail_trap_q <= 1'b0;
        end else begin
            if (div_wr) begin
                clock_divider_reg_q <= div_wdata;
            end
            // interrupt clearing wins over a software write
            if (irq_pending && clock_divider_reg_q[`PSC_DIV_ROI_BIT]) begin
                clock_divider_reg_q[`PSC_DIV_DOZE_ENABLE_BIT_BIT] <= 1'b0;
            end
            if (osc_wr && !cfg_locked) begin
                osc_control_reg_q <= osc_wdata;
                cur_osc_q <= osc_wdata[`PSC_OSC_NEW_HI:`PSC_OSC_NEW_LO];
            end
            if (is_state(state_q, ST_RUN) && power_save_instr_exec) begin
                sleep_src_q <= cur_osc_q;
            end
            if (in_sleep && wake_ev) begin
                cur_osc_q <= sleep_src_q;
            end
            clock_fail_trap_q <= fail_q;
            if (fail_q) begin
                cur_osc_q <= pll_in_use ? `PSC_SRC_FRC_PLL : `PSC_SRC_FRC;
            end
        end
    end

    // clock gating outputs
    assign sys_clk_run = !in_sleep;
    assign periph_clk_en = !in_sleep;
    assign cpu_running = is_state(state_q, ST_RUN);
    assign cpu_clk_en = cpu_running & cpu_tick;
    // rc runs while the watchdog is enabled, or outside sleep while the monitor is enabled
    assign low_power_rc_osc_run = in_sleep ? wdt_enable
        : (fail_mon_enable | wdt_enable);

    // failure detector, idle off in sleep
    psc_fail_mon u_fail (
        .clk(clk),
        .reset_n(reset_n),
        .active(fail_mon_enable & !in_sleep),
        .low_power_rc_osc_tick(low_power_rc_osc_tick),
        .sys_clk_seen(sys_clk_seen),
        .fail_q(fail_q)
    );

    // processor clock divider
    psc_doze_div u_doze (
        .clk(clk),
        .reset_n(reset_n),
        .doze_on(doze_bit),
        .ratio(clock_divider_reg_q[`PSC_DIV_RATIO_HI:`PSC_DIV_RATIO_LO]),
        .run(cpu_running),
        .cpu_tick_q(cpu_tick)
    );
endmodule // psc_power_ctrl

//--- tb/psc_osc_model.sv
// rc oscillator and system clock edge source
module psc_osc_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rc_run,
    input wire logic sys_run,
    input wire logic stall,
    output logic low_power_rc_osc_tick,
    output logic sys_clk_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_q; // rc period counter
    // rc ticks every eight cycles, only while kept running
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) div_q <= 3'h0;
        else if (rc_run) div_q <= div_q + 3'h1;
    end
    assign low_power_rc_osc_tick = rc_run && div_q == 3'h7;
    // edges vanish when the clock stops or the oscillator dies
    assign sys_clk_seen = sys_run && !stall;
endmodule // psc_osc_model

//--- tb/psc_props.sv
// port checks of the power controller
module psc_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_save_instr_exec,
    input wire logic power_save_instr_op,
    input wire logic irq_pending,
    input wire logic wdt_enable,
    input wire logic fail_mon_enable,
    input wire logic pll_in_use,
    input wire logic [15:0] clock_divider_reg_q,
    input wire logic [2:0] cur_osc_q,
    input wire logic clock_fail_trap_q,
    input wire logic sys_clk_run,
    input wire logic low_power_rc_osc_run,
    input wire logic periph_clk_en,
    input wire logic cpu_running,
    input wire logic watchdog_clear_q,
    input wire logic in_sleep,
    input wire logic in_idle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    idle_entry_a: assert property (cpu_running && power_save_instr_exec && power_save_instr_op
        |=> in_idle && !cpu_running) else $error("idle not entered");
    sleep_entry_a: assert property (cpu_running && power_save_instr_exec
        && !power_save_instr_op |=> in_sleep) else $error("sleep not entered");
    sleep_clock_a: assert property (in_sleep |-> !sys_clk_run
        && !periph_clk_en) else $error("clock runs in sleep");
    idle_clock_a: assert property (in_idle |-> sys_clk_run
        && periph_clk_en) else $error("clock stopped in idle");
    wdt_clear_a: assert property (cpu_running && power_save_instr_exec
        && wdt_enable |=> watchdog_clear_q) else $error("no wdt clear");
    rc_sleep_a: assert property (in_sleep && wdt_enable
        |-> low_power_rc_osc_run) else $error("rc off in sleep");
    rc_monitor_a: assert property (!in_sleep && fail_mon_enable
        |-> low_power_rc_osc_run) else $error("rc off with monitor");
    idle_wake_a: assert property (in_idle && irq_pending
        |=> !cpu_running ##[1:3] cpu_running) else $error("late wake");
    roi_clear_a: assert property (clock_divider_reg_q[15]
        && irq_pending |=> !clock_divider_reg_q[11]) else $error("doze kept");
    trap_src_a: assert property ($rose(clock_fail_trap_q)
        |-> cur_osc_q == {2'h0, pll_in_use}) else $error("bad fallback");
    cover property (in_idle ##1 !in_idle);
    cover property (in_sleep ##1 !in_sleep);
    cover property ($rose(clock_fail_trap_q));
endmodule // psc_props
bind psc_power_ctrl psc_props u_props (.*);

//--- tb/power_save_clock_monitor_test.sv
`include "psc_defines.vh"
// drives the power controller and checks its ports
module power_save_clock_monitor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, power_save_instr_exec, power_save_instr_op, irq_pending, wdt_enable;
    logic wdt_timeout, fail_mon_enable, low_power_rc_osc_tick, sys_clk_seen, stall;
    logic pll_in_use, cfg_locked, div_wr, osc_wr, clock_fail_trap_q;
    logic sys_clk_run, low_power_rc_osc_run, periph_clk_en, cpu_clk_en;
    logic cpu_running, watchdog_clear_q, in_sleep, in_idle;
    logic [15:0] div_wdata, osc_wdata, clock_divider_reg_q, osc_control_reg_q;
    logic [2:0] cur_osc_q;
    int err_total, cmp_count, cyc, n;
    // doze rows: divider value beside cpu ticks per 128 cycles
    logic [15:0] row_div [9] = '{16'h0800, 16'h1800, 16'h2800, 16'h3800,
        16'h4800, 16'h5800, 16'h6800, 16'h7800, 16'h7000};
    int row_cnt [9] = '{128, 64, 32, 16, 8, 4, 2, 1, 128};
    psc_power_ctrl dut (.*);
    psc_osc_model u_osc (.clk(clk), .reset_n(reset_n), .stall(stall),
        .rc_run(low_power_rc_osc_run), .sys_run(sys_clk_run),
        .low_power_rc_osc_tick(low_power_rc_osc_tick), .sys_clk_seen(sys_clk_seen));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic step(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one power-save instruction
    task automatic power_save_instr(logic op);
        power_save_instr_op = op;
        power_save_instr_exec = 1'b1;
        step();
        power_save_instr_exec = 1'b0;
    endtask
    // bounded wait for the cpu to run again
    task automatic wait_run;
        n = 0;
        while (cpu_running !== 1'b1 && n < 20) begin
            step();
            n++;
        end
    endtask
    task automatic wr_div(logic [15:0] v);
        div_wdata = v;
        div_wr = 1'b1;
        step();
        div_wr = 1'b0;
    endtask
    task automatic print_verdict;
        if (err_total == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        {power_save_instr_exec, power_save_instr_op, irq_pending, wdt_enable, wdt_timeout} = '0;
        {fail_mon_enable, pll_in_use, cfg_locked, div_wr, osc_wr} = '0;
        {stall, div_wdata, osc_wdata, reset_n} = '0;
        step(4);
        chk(clock_divider_reg_q, `PSC_DIV_RESET);
        chk({osc_control_reg_q[0], cpu_clk_en}, 2'h0);
        reset_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            wr_div(row_div[i]);
            step(130);
            n = 0;
            repeat (128) begin
                n += cpu_clk_en;
                step();
            end
            chk(16'(n), 16'(row_cnt[i]));
        end
        wdt_enable = 1'b1;
        power_save_instr(`PSC_OP_IDLE);
        chk({in_idle, watchdog_clear_q, periph_clk_en}, 3'h7);
        step(5);
        irq_pending = 1'b1;
        step();
        irq_pending = 1'b0;
        wait_run();
        chk(n >= `PSC_WAKE_MIN && n <= `PSC_WAKE_MAX, 1'b1);
        irq_pending = 1'b1;
        power_save_instr(`PSC_OP_IDLE);
        irq_pending = 1'b0;
        chk(in_idle, 1'b1);
        wait_run();
        chk(cpu_running, 1'b1);
        osc_wdata = 16'h0500;
        osc_wr = 1'b1;
        step();
        cfg_locked = 1'b1;
        osc_wdata = 16'h0200;
        step();
        osc_wr = 1'b0;
        chk({osc_control_reg_q, cur_osc_q}, {16'h0500, 3'h5});
        power_save_instr(`PSC_OP_SLEEP);
        chk({in_sleep, sys_clk_run, periph_clk_en}, 3'h4);
        step(3);
        wdt_timeout = 1'b1;
        step();
        wdt_timeout = 1'b0;
        wait_run();
        chk({in_sleep, cur_osc_q}, 4'h5);
        wr_div(16'hb800);
        irq_pending = 1'b1;
        step();
        irq_pending = 1'b0;
        chk(clock_divider_reg_q, 16'hb000);
        {fail_mon_enable, pll_in_use} = 2'h3;
        step(40);
        chk(clock_fail_trap_q, 1'b0);
        stall = 1'b1;
        step(60);
        chk({clock_fail_trap_q, cur_osc_q}, 4'h9);
        // monitor goes quiet once sleep has settled, despite the stall
        power_save_instr(`PSC_OP_SLEEP);
        step(2);
        chk({in_sleep, clock_fail_trap_q}, 2'h2);
        // a reset in mid-sleep wakes the device with registers reset
        reset_n = 1'b0;
        step();
        chk({in_sleep, cpu_running, clock_fail_trap_q}, 3'h2);
        chk(clock_divider_reg_q, `PSC_DIV_RESET);
        reset_n = 1'b1;
        step(2);
        chk({in_sleep, cpu_running}, 2'h1);
        print_verdict();
    end
endmodule // power_save_clock_monitor_test
